// File: design/adc_conversion_status_flags.v
// Purpose: result storage and status flags of a converter controller
// Assumes: software read strobes and conversion-done pulses are on clk
// Notes:   flags are plain ports, no register bus
`include "adc_flags_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_status_flags (
    input  wire                         clk,
    input  wire                         resetn,
    input  wire [`NCH-1:0]              chan_enable,
    input  wire                         conv_start,
    input  wire                         conv_done,
    input  wire [`CHW-1:0]              conv_chan,
    input  wire [`RESW-1:0]             conv_result,
    input  wire                         sleep_select,
    input  wire                         rd_last,
    input  wire                         rd_chan,
    input  wire [`CHW-1:0]              rd_chan_sel,
    input  wire                         rd_status,
    output reg  [`RESW-1:0]             last_result_register,
    output wire [`NCH*`RESW-1:0]        channel_result_register,
    output reg  [`NCH-1:0]              eoc_flag,
    output reg  [`NCH-1:0]              channel_overrun_flag,
    output reg                          data_ready_flag,
    output reg                          global_overrun_flag,
    output reg  [`CHW-1:0]              last_chan,
    output reg                          converting,
    output reg                          asleep
);
    // ----------------------------------------------------------------
    // conversion tracking
    // ----------------------------------------------------------------
    reg  [`RESW-1:0] res_q [0:`NCH-1];
    wire             store;
    wire [`NCH-1:0]  done_vec;
    wire [`NCH-1:0]  rd_vec;
    wire             new_govr;

    assign store    = conv_done & chan_enable[conv_chan];
    assign done_vec = store ? ({{(`NCH-1){1'b0}}, 1'b1} << conv_chan) : `CH_RST;
    assign rd_vec   = rd_chan ? ({{(`NCH-1){1'b0}}, 1'b1} << rd_chan_sel) : `CH_RST;
    assign new_govr = store & (data_ready_flag | eoc_flag[conv_chan]);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            converting  <= `MODE_IDLE;
            asleep      <= 1'b0;
        end else begin
            if (conv_start) begin
                converting <= `MODE_CONV;
                asleep     <= 1'b0;
            end else if (conv_done) begin
                converting <= `MODE_IDLE;
                asleep     <= sleep_select;
            end
        end
    end

    // ----------------------------------------------------------------
    // result registers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `NCH; g = g + 1) begin : gen_ch
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    res_q[g] <= `RES_RST;
                end else if (done_vec[g]) begin
                    res_q[g] <= conv_result;
                end
            end
            assign channel_result_register[g*`RESW +: `RESW] = res_q[g];

            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    eoc_flag[g]             <= 1'b0;
                    channel_overrun_flag[g] <= 1'b0;
                end else begin
                    if (done_vec[g])
                        eoc_flag[g] <= 1'b1;
                    else if (rd_vec[g] | (rd_last & (last_chan == g)))
                        eoc_flag[g] <= 1'b0;
                    if (done_vec[g] & eoc_flag[g])
                        channel_overrun_flag[g] <= 1'b1;
                    else if (rd_status)
                        channel_overrun_flag[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // shared flags
    // ----------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_result_register <= `RES_RST;
            last_chan            <= {`CHW{1'b0}};
            data_ready_flag      <= 1'b0;
            global_overrun_flag  <= 1'b0;
        end else begin
            if (store) begin
                last_result_register <= conv_result;
                last_chan            <= conv_chan;
            end
            if (store)
                data_ready_flag <= 1'b1;
            else if (rd_last)
                data_ready_flag <= 1'b0;
            if (new_govr)
                global_overrun_flag <= 1'b1;
            else if (rd_status)
                global_overrun_flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: design/adc_flags_defines.vh
// Purpose: constants for the conversion status flag block
// Assumes: eight channels, ten-bit results
// Notes:   included by its bare name
`ifndef ADC_FLAGS_DEFINES_VH
`define ADC_FLAGS_DEFINES_VH
`define NCH          8
`define CHW          3
`define RESW         10
`define RES_RST      10'h000
`define CH_RST       8'h00
`define MODE_IDLE    1'b0
`define MODE_CONV    1'b1
`endif

// File: tb/adc_conversion_status_flags_tb.sv
// Purpose: flag block bench
// Assumes: done two edges after start
// Notes:   reads meet the done pulse
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_status_flags_tb;
logic clk = 0, resetn = 0, conv_start = 0, conv_done, sleep_select = 0, converting, asleep;
logic rd_last = 0, rd_chan = 0, rd_status = 0, data_ready_flag, global_overrun_flag;
logic [2:0] ch = 0, rd_chan_sel = 0, conv_chan, last_chan;
logic [7:0] chan_enable = 0, eoc_flag, channel_overrun_flag;
logic [9:0] conv_result, last_result_register;
logic [79:0] channel_result_register;
int errors = 0, cmp_count = 0;
always #5 clk = ~clk;
adc_conversion_status_flags uut (.*);
conv_core_model #(.DLY(1)) core (.clk, .conv_start, .ch_in(ch), .conv_done, .conv_chan,
    .conv_result);
task automatic chk(input logic [9:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
        errors++;
        $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
endtask
task automatic tally_and_finish;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
task automatic sc(input logic [2:0] c, input logic [7:0] en, input logic [2:0] rd, s,
        input logic [9:0] dr, gov, eoc, ovr);
    @(posedge clk);
    conv_start <= 1'b1;
    ch <= c;
    chan_enable <= 8'hFF;
    @(posedge clk);
    conv_start <= 1'b0;
    @(posedge clk);
    chan_enable <= en;
    chk(converting, 1);
    {rd_last, rd_chan, rd_status} <= rd;
    rd_chan_sel <= s;
    @(posedge clk);
    {rd_last, rd_chan, rd_status} <= 3'h0;
    @(negedge clk);
    chk(data_ready_flag, dr);
    chk(global_overrun_flag, gov);
    chk(eoc_flag, eoc);
    chk(channel_overrun_flag, ovr);
    chk(converting, 0);
    if (en[c]) chk(last_result_register, {c, 7'h5A});
    if (en[c]) chk(channel_result_register[c*10 +: 10], {c, 7'h5A});
    if (en[c]) chk(last_chan, c);
    $display("case done");
endtask
initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    sc(2, 8'hFF, 3'h0, 0, 1, 0, 8'h04, 8'h00);
    sc(5, 8'hFF, 3'h2, 2, 1, 1, 8'h20, 8'h00);
    sc(5, 8'hFD, 3'h1, 0, 1, 1, 8'h20, 8'h20);
    sc(3, 8'hFF, 3'h1, 0, 1, 1, 8'h28, 8'h00);
    sc(6, 8'hBF, 3'h4, 0, 0, 1, 8'h20, 8'h00);
    sc(0, 8'hFF, 3'h1, 0, 1, 0, 8'h21, 8'h00);
    @(posedge clk);
    sleep_select <= 1'b1;
    sc(0, 8'hFF, 3'h0, 0, 1, 1, 8'h21, 8'h01);
    chk(asleep, 1);
    tally_and_finish;
end
initial begin
    #5000;
    errors++;
    tally_and_finish;
end
endmodule
`default_nettype wire

// File: tb/adc_flags_monitor.sv
// Purpose: flag relations
// Assumes: one clock
// Notes:   bound below
`timescale 1ns/1ns
`default_nettype none
module adc_flags_monitor (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [7:0] chan_enable,
    input wire logic       conv_done,
    input wire logic [2:0] conv_chan,
    input wire logic       rd_last,
    input wire logic       rd_status,
    input wire logic [7:0] eoc_flag,
    input wire logic [7:0] channel_overrun_flag,
    input wire logic       data_ready_flag,
    input wire logic       global_overrun_flag
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
wire st = conv_done && chan_enable[conv_chan];
sequence stored; st; endsequence
dr_set_a: assert property (stored |=> data_ready_flag) else $error("ready");
dr_keep_a: assert property (data_ready_flag && !rd_last |=> data_ready_flag) else $error("lost");
dr_idle_a: assert property (!st && !data_ready_flag |=> !data_ready_flag) else $error("rise");
gov_set_a: assert property (stored ##0 data_ready_flag |=> global_overrun_flag) else $error("gov");
gov_clr_a: assert property (rd_status && !(st && (data_ready_flag || eoc_flag[conv_chan]))
    |=> !global_overrun_flag) else $error("gov clr");
eoc_set_a: assert property (stored |=> eoc_flag[$past(conv_chan)]) else $error("eoc");
ovr_set_a: assert property (stored ##0 eoc_flag[conv_chan]
    |=> channel_overrun_flag[$past(conv_chan)]) else $error("ovr");
ovr_clr_a: assert property (rd_status && !(st && eoc_flag[conv_chan])
    |=> channel_overrun_flag == 8'h00) else $error("ovr clr");
endmodule
bind adc_conversion_status_flags adc_flags_monitor mon (.*);
`default_nettype wire

// File: tb/conv_core_model.sv
// Purpose: conversion core stand-in
// Assumes: start one cycle wide
// Notes:   idle result lines invert
`timescale 1ns/1ns
`default_nettype none
module conv_core_model #(parameter int DLY = 1) (
    input  wire logic       clk,
    input  wire logic       conv_start,
    input  wire logic [2:0] ch_in,
    output var  logic       conv_done,
    output var  logic [2:0] conv_chan,
    output var  logic [9:0] conv_result
);
int n = 0;
always @(posedge clk) begin
    n <= conv_start ? DLY : (n > 0 ? n - 1 : 0);
    conv_done <= n == 1;
    conv_chan <= ch_in;
    conv_result <= n == 1 ? {ch_in, 7'h5A} : ~conv_result;
end
endmodule
`default_nettype wire
